// File: include/pucrs_pkg.sv
// Package for the power-up clock reference select block
package pucrs_pkg;

   // ==========================================================
   // Strap layout
   localparam int unsigned STRAP_W     = 11;
   localparam int unsigned SEL_W       = 5;
   localparam logic [4:0]  SEL_OSC_LO  = 5'h00;
   localparam logic [4:0]  SEL_OSC_HI  = 5'h07;
   localparam logic [4:0]  SEL_BCK_LO  = 5'h08;
   localparam logic [4:0]  SEL_BCK_HI  = 5'h0b;

   // ==========================================================
   // Divider settings giving a 400 MHz loop output
   localparam int unsigned REFDIV_W    = 6;
   localparam int unsigned FBDIV_W     = 10;
   localparam int unsigned LOOP_OUT_MHZ = 400;
   localparam int unsigned CORE_DIV    = 4;
   localparam logic [5:0]  REFDIV_RST  = 6'h01;
   localparam logic [9:0]  FBDIV_RST   = 10'h000;

   // ==========================================================
   // Sequence timing, 25 MHz system clock
   localparam int unsigned CLK_PERIOD_PS  = 40000;
   localparam int unsigned T_LATCH_PS     = 1500000;
   localparam int unsigned T_TMS_PS       = 400000;
   localparam int unsigned T_SRST_PS      = 600000;
   localparam int unsigned CNT_W          = 8;
   localparam logic [7:0] LATCH_CYC = CNT_W'((T_LATCH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] TMS_CYC   = CNT_W'((T_TMS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] SRST_CYC  = CNT_W'((T_SRST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PUCRS_SRC_NONE = 2'b00,
      PUCRS_SRC_OSC  = 2'b01,
      PUCRS_SRC_BCK  = 2'b10
   } pucrs_src_type;

   typedef struct packed {
      pucrs_src_type   src;
      logic [5:0]      refDiv;
      logic [9:0]      fbDiv;
      logic            bypass;
      logic            invalid;
   } pucrs_pllcfg_type;

endpackage : pucrs_pkg

// File: src/pucrs_decode.sv
// Strap code to loop reference and divider decode
`timescale 1ns/1ps
`default_nettype none
module pucrs_decode
   import pucrs_pkg::*;
(
   input  wire logic [4:0]       sel,
   output var pucrs_pllcfg_type  cfg
);

   // ==========================================================
   // Decode table, reference divided to 2.048 or 1 MHz-class compare
   always_comb begin
      cfg        = '{src: PUCRS_SRC_NONE, refDiv: REFDIV_RST, fbDiv: FBDIV_RST,
                     bypass: 1'b1, invalid: 1'b1};
      unique case (sel)
         5'h00: cfg = '{PUCRS_SRC_OSC, 6'h14, 10'h190, 1'b0, 1'b0};
         5'h01: cfg = '{PUCRS_SRC_OSC, 6'h19, 10'h190, 1'b0, 1'b0};
         5'h02: cfg = '{PUCRS_SRC_OSC, 6'h01, 10'h0c3, 1'b0, 1'b0};
         5'h03: cfg = '{PUCRS_SRC_OSC, 6'h02, 10'h0c3, 1'b0, 1'b0};
         5'h04: cfg = '{PUCRS_SRC_OSC, 6'h04, 10'h0c3, 1'b0, 1'b0};
         5'h05: cfg = '{PUCRS_SRC_OSC, 6'h06, 10'h0c3, 1'b0, 1'b0};
         5'h06: cfg = '{PUCRS_SRC_OSC, 6'h08, 10'h0c3, 1'b0, 1'b0};
         5'h07: cfg = '{PUCRS_SRC_OSC, 6'h0c, 10'h0c3, 1'b0, 1'b0};
         5'h08: cfg = '{PUCRS_SRC_BCK, 6'h01, 10'h0c3, 1'b0, 1'b0};
         5'h09: cfg = '{PUCRS_SRC_BCK, 6'h02, 10'h0c3, 1'b0, 1'b0};
         5'h0a: cfg = '{PUCRS_SRC_BCK, 6'h04, 10'h0c3, 1'b0, 1'b0};
         5'h0b: cfg = '{PUCRS_SRC_BCK, 6'h08, 10'h0c3, 1'b0, 1'b0};
         default: ;
      endcase
   end

endmodule : pucrs_decode
`default_nettype wire

// File: src/pucrs_top.sv
// Power-up clock reference select and strap capture sequencer
`timescale 1ns/1ps
`default_nettype none
module pucrs_top
   import pucrs_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   input  wire logic [10:0]         strapPins,
   input  wire logic                pllLocked,
   input  wire logic                wdogReset,
   input  wire logic                loopClkTick,
   input  wire logic                primaryLowRateSlave,
   input  wire logic [2:0]          primaryTimingMode,
   input  wire logic [2:0]          portMasterReq,
   output logic                     pllBypass,
   output logic [1:0]               pllRefSrc,
   output logic [5:0]               pllRefDiv,
   output logic [9:0]               pllFbDiv,
   output logic                     pllTimingModeStrobe,
   output logic                     selInvalid,
   output logic [10:0]              startupStatus,
   output logic [10:0]              pinStatus,
   output logic                     strapLatchPulse,
   output logic                     syncReset_b,
   output logic                     coreClkEn,
   output logic                     timingGenClkEn,
   output logic                     primaryModeAllowed,
   output logic                     primaryFollowsLowRate,
   output logic [2:0]               portMaster
);

   // ==========================================================
   // Reset synchroniser
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ==========================================================
   // Live strap decode, registered to the loop during lock wait and at the strobe
   pucrs_pllcfg_type liveCfg;
   pucrs_decode u_decode (
      .sel (strapPins[4:0]),
      .cfg (liveCfg)
   );

   // ==========================================================
   // Sequencer
   typedef enum logic [2:0] {
      PUCRS_ST_LOCKWAIT = 3'b000,
      PUCRS_ST_LATCH    = 3'b001,
      PUCRS_ST_TMS      = 3'b010,
      PUCRS_ST_SRST     = 3'b011,
      PUCRS_ST_RUN      = 3'b100
   } pucrs_state_type;

   pucrs_state_type state_q;
   logic [7:0]      cnt_q;
   logic            capDone_q;

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         state_q <= PUCRS_ST_LOCKWAIT;
         cnt_q   <= 8'h00;
      end else begin
         unique case (state_q)
            PUCRS_ST_LOCKWAIT: begin
               if (!pllLocked) begin
                  cnt_q <= 8'h00;
               end else if (cnt_q == LATCH_CYC - 8'h01) begin
                  state_q <= PUCRS_ST_LATCH;
                  cnt_q   <= 8'h00;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            PUCRS_ST_LATCH: begin
               if (cnt_q == TMS_CYC - 8'h01) begin
                  state_q <= PUCRS_ST_TMS;
                  cnt_q   <= 8'h00;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            PUCRS_ST_TMS: begin
               if (cnt_q == SRST_CYC - 8'h02) begin
                  state_q <= PUCRS_ST_SRST;
                  cnt_q   <= 8'h00;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            PUCRS_ST_SRST: begin
               state_q <= PUCRS_ST_RUN;
            end
            PUCRS_ST_RUN: begin
               if (wdogReset) begin
                  state_q <= PUCRS_ST_LATCH;
                  cnt_q   <= TMS_CYC - 8'h01;
               end
            end
            default: begin
               state_q <= PUCRS_ST_LOCKWAIT;
               cnt_q   <= 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // Strap capture, once per external reset
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         startupStatus   <= 11'h000;
         capDone_q       <= 1'b0;
         strapLatchPulse <= 1'b0;
      end else begin
         strapLatchPulse <= 1'b0;
         if (state_q == PUCRS_ST_LOCKWAIT && pllLocked && cnt_q == LATCH_CYC - 8'h01 && !capDone_q) begin
            startupStatus   <= strapPins;
            capDone_q       <= 1'b1;
            strapLatchPulse <= 1'b1;
         end
      end
   end

   // Run-time pin status, separate register
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         pinStatus <= 11'h000;
      end else begin
         pinStatus <= strapPins;
      end
   end

   // ==========================================================
   // Loop configuration; live during lock wait, held through strap latch, latched again at strobe
   logic tmsFire;
   assign tmsFire = (state_q == PUCRS_ST_LATCH) && (cnt_q == TMS_CYC - 8'h01);

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         pllBypass           <= 1'b1;
         pllRefSrc           <= PUCRS_SRC_NONE;
         pllRefDiv           <= REFDIV_RST;
         pllFbDiv            <= FBDIV_RST;
         selInvalid          <= 1'b0;
         pllTimingModeStrobe <= 1'b0;
      end else begin
         pllTimingModeStrobe <= tmsFire;
         if (state_q == PUCRS_ST_LOCKWAIT || tmsFire) begin
            pllBypass  <= liveCfg.bypass;
            pllRefSrc  <= liveCfg.src;
            pllRefDiv  <= liveCfg.refDiv;
            pllFbDiv   <= liveCfg.fbDiv;
            selInvalid <= liveCfg.invalid;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         syncReset_b <= 1'b0;
      end else begin
         syncReset_b <= (state_q == PUCRS_ST_RUN) && !wdogReset;
      end
   end

   // ==========================================================
   // Clock enables derived from loop-rate tick
   logic [1:0] divCnt_q;
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         divCnt_q       <= 2'h0;
         coreClkEn      <= 1'b0;
         timingGenClkEn <= 1'b0;
      end else begin
         timingGenClkEn <= loopClkTick && !pllBypass;
         coreClkEn      <= 1'b0;
         if (loopClkTick) begin
            divCnt_q <= divCnt_q + 2'h1;
            coreClkEn <= (divCnt_q == 2'(CORE_DIV - 1));
         end
      end
   end

   // ==========================================================
   // Audio port timing permissions
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         primaryModeAllowed    <= 1'b1;
         primaryFollowsLowRate <= 1'b0;
         portMaster            <= 3'h0;
      end else begin
         primaryModeAllowed <= !(pllRefSrc == PUCRS_SRC_BCK &&
                                 (primaryTimingMode == 3'h2 || primaryTimingMode == 3'h5));
         primaryFollowsLowRate <= (pllRefSrc == PUCRS_SRC_OSC) && primaryLowRateSlave;
         portMaster <= portMasterReq;
      end
   end

endmodule : pucrs_top
`default_nettype wire

// File: test/pucrs_top_props.sv
// Concurrent checks on the clock reference select block
`timescale 1ns/1ps
`default_nettype none
module pucrs_top_props (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [10:0] strapPins,
   input wire logic        pllLocked,
   input wire logic        pllBypass,
   input wire logic [1:0]  pllRefSrc,
   input wire logic        pllTimingModeStrobe,
   input wire logic        selInvalid,
   input wire logic [10:0] startupStatus,
   input wire logic [10:0] pinStatus,
   input wire logic        strapLatchPulse,
   input wire logic        syncReset_b
);
   // ==========================================================
   // Helpers
   logic [4:0] code;
   assign code = startupStatus[4:0];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Sequence and decode
   chk_latch_lock: assert property (strapLatchPulse |-> $past(pllLocked, 30))
      else $error("latch pulse without lock");
   chk_strobe_after: assert property (strapLatchPulse |-> ##[8:12] pllTimingModeStrobe)
      else $error("strobe late after latch");
   chk_srst_release: assert property (pllTimingModeStrobe |-> !syncReset_b ##[10:20] $rose(syncReset_b))
      else $error("sync reset release late");
   chk_status_hold: assert property (!strapLatchPulse && !$past(strapLatchPulse) |-> $stable(startupStatus))
      else $error("startup status changed");
   chk_status_capture: assert property (strapLatchPulse |-> startupStatus == pinStatus)
      else $error("startup status wrong");
   chk_pin_follow: assert property (syncReset_b |-> pinStatus == $past(strapPins))
      else $error("pin status wrong");
   chk_src_code: assert property (syncReset_b |-> pllRefSrc == (code < 5'h08 ? 2'h1 : code < 5'h0c ? 2'h2 : 2'h0))
      else $error("reference source wrong");
   chk_bad_code: assert property (syncReset_b && code > 5'h0b |-> selInvalid && pllBypass)
      else $error("reserved code not bypassed");
   chk_good_code: assert property (syncReset_b && code < 5'h0c |-> !selInvalid && !pllBypass)
      else $error("valid code bypassed");
   cov_latch: cover property (strapLatchPulse);
   cov_strobe: cover property (pllTimingModeStrobe);
   cov_invalid: cover property (syncReset_b && selInvalid);
endmodule : pucrs_top_props
bind pucrs_top pucrs_top_props chk (.sys_clk(sys_clk), .rst_b(rst_b), .strapPins(strapPins),
   .pllLocked(pllLocked), .pllBypass(pllBypass), .pllRefSrc(pllRefSrc),
   .pllTimingModeStrobe(pllTimingModeStrobe), .selInvalid(selInvalid), .startupStatus(startupStatus),
   .pinStatus(pinStatus), .strapLatchPulse(strapLatchPulse), .syncReset_b(syncReset_b));
`default_nettype wire

// File: test/pucrs_clk_src.sv
// Model of the board timing source and loop lock
`timescale 1ns/1ps
`default_nettype none
module pucrs_clk_src (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] lockDelay,
   output logic            pllLocked,
   output logic            loopClkTick
);
   logic [7:0] waitCnt_q;
   // ==========================================================
   // Lock some cycles after reset release; ticks only when locked
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt_q <= 8'h00;
         pllLocked <= 1'b0;
      end else if (waitCnt_q < lockDelay) begin
         waitCnt_q <= waitCnt_q + 8'h01;
      end else begin
         pllLocked <= 1'b1;
      end
   end
   assign loopClkTick = pllLocked;
endmodule : pucrs_clk_src
`default_nettype wire

// File: test/tb_top.sv
// Testbench for the clock reference select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [10:0] strapPins = 11'h000;
   logic wdogReset = 1'b0;
   logic primaryLowRateSlave = 1'b0;
   logic [2:0] primaryTimingMode = 3'h0;
   logic [2:0] portMasterReq = 3'h0;
   logic [7:0] lockDelay = 8'h05;
   logic pllLocked, loopClkTick, pllBypass, pllTimingModeStrobe, selInvalid;
   logic strapLatchPulse, syncReset_b, coreClkEn, timingGenClkEn;
   logic primaryModeAllowed, primaryFollowsLowRate;
   logic [1:0] pllRefSrc;
   logic [5:0] pllRefDiv;
   logic [9:0] pllFbDiv;
   logic [10:0] startupStatus, pinStatus, s0;
   logic [2:0] portMaster, m;
   logic [4:0] code;
   int miscompares = 0;
   int checks = 0;
   int latchCnt, strbCnt, coreCnt, tgCnt, n;
   always #20 sys_clk = ~sys_clk;
   pucrs_clk_src src (.sys_clk(sys_clk), .rst_b(rst_b), .lockDelay(lockDelay), .pllLocked(pllLocked),
      .loopClkTick(loopClkTick));
   pucrs_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .strapPins(strapPins), .pllLocked(pllLocked),
      .wdogReset(wdogReset), .loopClkTick(loopClkTick), .primaryLowRateSlave(primaryLowRateSlave),
      .primaryTimingMode(primaryTimingMode), .portMasterReq(portMasterReq), .pllBypass(pllBypass),
      .pllRefSrc(pllRefSrc), .pllRefDiv(pllRefDiv), .pllFbDiv(pllFbDiv),
      .pllTimingModeStrobe(pllTimingModeStrobe), .selInvalid(selInvalid), .startupStatus(startupStatus),
      .pinStatus(pinStatus), .strapLatchPulse(strapLatchPulse), .syncReset_b(syncReset_b),
      .coreClkEn(coreClkEn), .timingGenClkEn(timingGenClkEn), .primaryModeAllowed(primaryModeAllowed),
      .primaryFollowsLowRate(primaryFollowsLowRate), .portMaster(portMaster));
   // ==========================================================
   // Pulse counters
   always @(posedge sys_clk) begin
      latchCnt += int'(strapLatchPulse === 1'b1);
      strbCnt += int'(pllTimingModeStrobe === 1'b1);
      coreCnt += int'(coreClkEn === 1'b1);
      tgCnt += int'(timingGenClkEn === 1'b1);
   end
   // ==========================================================
   // Tasks
   function automatic logic [1:0] exp_src(input logic [4:0] c);
      return c < 5'h08 ? 2'h1 : (c < 5'h0c ? 2'h2 : 2'h0);
   endfunction : exp_src
   function automatic int ref_khz(input logic [4:0] c);
      int tbl [12] = '{20000, 25000, 2048, 4096, 8192, 12288, 16384, 24576, 2048, 4096, 8192, 16384};
      return c < 5'h0c ? tbl[c] : 0;
   endfunction : ref_khz
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic wait_run();
      n = 0;
      while (syncReset_b !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      chk(11'(n < 300), 11'h001);
   endtask : wait_run
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(97615));
      for (int i = 0; i < 16; i++) begin
         code = i < 12 ? 5'(i) : (i == 12 ? 5'h0c : (i == 13 ? 5'h1f : 5'($urandom_range(13, 30))));
         @(negedge sys_clk);
         rst_b = 1'b0;
         strapPins = {6'($urandom), code};
         lockDelay = 8'($urandom_range(1, 20));
         repeat (10) @(negedge sys_clk);
         latchCnt = 0;
         strbCnt = 0;
         rst_b = 1'b1;
         wait_run();
         chk(startupStatus, strapPins);
         chk(11'(latchCnt), 11'h001);
         chk(11'(strbCnt), 11'h001);
         chk(11'(pllRefSrc), 11'(exp_src(code)));
         chk(11'({selInvalid, pllBypass}), code > 5'h0b ? 11'h003 : 11'h000);
         n = ref_khz(code) * int'(pllFbDiv) / (pllRefDiv != 6'h00 ? int'(pllRefDiv) : 1) - 400000;
         if (code < 5'h0c) chk(11'(n > -2000 && n < 2000), 11'h001);
         if (code > 5'h0b) chk(11'(pllRefDiv), 11'(pucrs_pkg::REFDIV_RST));
         if (code > 5'h0b) chk(11'(pllFbDiv), 11'(pucrs_pkg::FBDIV_RST));
         coreCnt = 0;
         tgCnt = 0;
         repeat (40) @(negedge sys_clk);
         if (code < 5'h0c) chk(11'(coreCnt), 11'h00a);
         chk(11'(tgCnt), code < 5'h0c ? 11'h028 : 11'h000);
         m = i[0] ? (i[1] ? 3'h2 : 3'h5) : 3'($urandom);
         primaryTimingMode = m;
         primaryLowRateSlave = 1'($urandom);
         portMasterReq = 3'($urandom);
         s0 = startupStatus;
         strapPins[10:5] = ~strapPins[10:5];
         repeat (3) @(negedge sys_clk);
         chk(11'(primaryModeAllowed), 11'(!(code > 5'h07 && code < 5'h0c && (m == 3'h2 || m == 3'h5))));
         chk(11'(portMaster), 11'(portMasterReq));
         chk(11'(primaryFollowsLowRate), 11'(code < 5'h08 && primaryLowRateSlave));
         chk(pinStatus, strapPins);
         chk(startupStatus, s0);
         latchCnt = 0;
         strbCnt = 0;
         wdogReset = 1'b1;
         @(negedge sys_clk);
         wdogReset = 1'b0;
         @(negedge sys_clk);
         wait_run();
         chk(11'(latchCnt), 11'h000);
         chk(11'(strbCnt), 11'h001);
         chk(startupStatus, s0);
      end
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
